// ---- common/sdi_regs.svh ----
// Constants for the serial audio input stage of the digital-audio transmitter.
// Assumes inclusion by bare name from both ends and the package.
`ifndef SDI_REGS_SVH
`define SDI_REGS_SVH
`define SDI_FMT_LJ        2'h0
`define SDI_FMT_I2S       2'h1
`define SDI_FMT_RJ        2'h2
`define SDI_FMT_RESET     2'h1
`define SDI_WID_16        2'h0
`define SDI_WID_18        2'h1
`define SDI_WID_20        2'h2
`define SDI_WID_24        2'h3
`define SDI_SLOTS_PER_CH  6'h20
`define SDI_SAMPLE_BITS   24
`define SDI_CLK_PERIOD_NS 25
`define SDI_BCLK_PERIOD_NS 200
`define SDI_BCLK_HALF     ((`SDI_BCLK_PERIOD_NS / 2) / `SDI_CLK_PERIOD_NS)
`endif

// ---- common/sdi_pkg.sv ----
// Types shared by both ends of the serial audio input link.
// Assumes sdi_regs.svh on the include path.
`include "sdi_regs.svh"
package sdi_pkg;
    typedef logic [1:0]                    sdi_fmt_t;
    typedef logic [1:0]                    sdi_wid_t;
    typedef logic [`SDI_SAMPLE_BITS-1:0]   sdi_sample_t;
endpackage : sdi_pkg

// ---- common/sdi_link_if.sv ----
// Serial audio link: bit clock, channel-select clock and serial data.
// Assumes the source end drives all three lines and the sink only samples.
`timescale 1ns/1ps
interface sdi_link_if;
    logic bit_clk;
    logic chan_sel;
    logic serial_sample_in;
    modport source (output bit_clk, output chan_sel, output serial_sample_in);
    modport sink   (input bit_clk, input chan_sel, input serial_sample_in);
endinterface : sdi_link_if

// ---- hw/sdi_sink.sv ----
// Serial audio input stage: captures left and right samples from the link.
// Assumes the link lines are asynchronous to core_clk and slower than it by 4x or more.
// Functional notes
// - Accept LJ, I2S, RJ at 16/18/20/24 bits.
// - Reset selects I2S format.
// - LJ and RJ: select high means left.
// - I2S: select low means left.
// - Sample data and select on bit-clock rise.
// - RJ MSB at slot 12 (20b), 16 (16b).
// - RJ sample ends just before next transition.
// - I2S MSB one slot after transition.
// - LJ MSB in first slot after transition.
`timescale 1ns/1ps
`include "sdi_regs.svh"
module sdi_sink (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                nrst,
    // Configuration
    input  wire sdi_pkg::sdi_fmt_t   fmt_sel,
    input  wire logic                fmt_override,
    input  wire sdi_pkg::sdi_wid_t   wid_sel,
    // Link
    sdi_link_if.sink                 link,
    // Sample output towards the transmitter core
    output logic                     smp_valid,
    input  wire logic                smp_ready,
    output sdi_pkg::sdi_sample_t     smp_data,
    output logic                     smp_left
);
    logic [1:0] bclk_s_reg, lr_s_reg, sd_s_reg;
    logic       bclk_d_reg;
    logic       lr_prev_reg, lr_prev_next;
    logic [5:0] slot_reg, slot_next;
    sdi_pkg::sdi_sample_t shift_reg, shift_next;
    logic [4:0] left_reg, left_next;
    logic       cur_left_reg, cur_left_next;
    logic       wr_valid;
    sdi_pkg::sdi_sample_t wr_data;
    logic       wr_left;
    logic       wr_ready;
    sdi_pkg::sdi_fmt_t fmt;
    logic [5:0] width, first_slot;
    logic       rise, lr_now, edge_lr, in_word;

    // Two stages on every link line before any logic looks at it.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bclk_s_reg <= 2'h0;
            lr_s_reg   <= 2'h0;
            sd_s_reg   <= 2'h0;
            bclk_d_reg <= 1'b0;
        end else begin
            bclk_s_reg <= {bclk_s_reg[0], link.bit_clk};
            lr_s_reg   <= {lr_s_reg[0], link.chan_sel};
            sd_s_reg   <= {sd_s_reg[0], link.serial_sample_in};
            bclk_d_reg <= bclk_s_reg[1];
        end
    end

    always_comb begin
        fmt = fmt_override ? fmt_sel : `SDI_FMT_RESET;
        unique case (wid_sel)
            `SDI_WID_16: width = 6'd16;
            `SDI_WID_18: width = 6'd18;
            `SDI_WID_20: width = 6'd20;
            default:     width = 6'd24;
        endcase
        unique case (fmt)
            `SDI_FMT_I2S: first_slot = 6'd1;
            `SDI_FMT_RJ:  first_slot = `SDI_SLOTS_PER_CH - width;
            default:      first_slot = 6'd0;
        endcase
    end

    // Data and select are all synchronised by equal depth, so they line up with the edge.
    assign rise    = bclk_s_reg[1] & ~bclk_d_reg;
    assign lr_now  = lr_s_reg[1];
    assign edge_lr = lr_now != lr_prev_reg;

    always_comb begin
        lr_prev_next  = lr_prev_reg;
        slot_next     = slot_reg;
        shift_next    = shift_reg;
        left_next     = left_reg;
        cur_left_next = cur_left_reg;
        wr_valid      = 1'b0;
        wr_data       = shift_reg;
        wr_left       = cur_left_reg;
        in_word       = 1'b0;
        if (rise) begin
            lr_prev_next = lr_now;
            if (edge_lr) begin
                slot_next = 6'h0;
                left_next = width[4:0];
                // The I2S select is inverted relative to LJ and RJ.
                cur_left_next = (fmt == `SDI_FMT_I2S) ? ~lr_now : lr_now;
            end else if (slot_reg != 6'h3f) begin
                slot_next = slot_reg + 6'h1;
            end
            in_word = (slot_next >= first_slot) && (slot_next < first_slot + width);
            if (in_word && left_next != 5'h0) begin
                shift_next = {shift_reg[`SDI_SAMPLE_BITS-2:0], sd_s_reg[1]};
                left_next  = left_next - 5'h1;
                if (left_next == 5'h0) begin
                    // A short word is left-aligned in the 24-bit sample.
                    wr_valid = 1'b1;
                    wr_data  = sdi_pkg::sdi_sample_t'(
                               {shift_reg[`SDI_SAMPLE_BITS-2:0], sd_s_reg[1]}
                               << (6'd24 - width));
                    wr_left  = cur_left_next;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lr_prev_reg  <= 1'b0;
            slot_reg     <= 6'h3f;
            shift_reg    <= '0;
            left_reg     <= 5'h0;
            cur_left_reg <= 1'b0;
        end else begin
            lr_prev_reg  <= lr_prev_next;
            slot_reg     <= slot_next;
            shift_reg    <= shift_next;
            left_reg     <= left_next;
            cur_left_reg <= cur_left_next;
        end
    end

    // Two-entry buffer; a word arriving while full is dropped, since the link cannot stall.
    logic [1:0] cnt_reg, cnt_next;
    logic       rd_reg, rd_next, wp_reg, wp_next;
    sdi_pkg::sdi_sample_t ent_data [2];
    logic       ent_side [2];
    logic       push, pop;
    assign wr_ready  = cnt_reg != 2'h2;
    assign push      = wr_valid & wr_ready;
    assign smp_valid = cnt_reg != 2'h0;
    assign pop       = smp_valid & smp_ready;
    assign smp_data  = ent_data[rd_reg];
    assign smp_left  = ent_side[rd_reg];

    always_comb begin
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
        rd_next  = pop ? ~rd_reg : rd_reg;
        wp_next  = push ? ~wp_reg : wp_reg;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 2'h0;
            rd_reg  <= 1'b0;
            wp_reg  <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            rd_reg  <= rd_next;
            wp_reg  <= wp_next;
        end
    end

    // Only the entry under the write pointer loads, so a pending word is never overwritten.
    for (genvar e = 0; e < 2; e++) begin : g_entry
        sdi_pkg::sdi_sample_t word_reg, word_next;
        logic                 side_bit_reg, side_bit_next;
        logic                 load;
        assign load = push && (wp_reg == 1'(e));
        always_comb begin
            word_next     = load ? wr_data : word_reg;
            side_bit_next = load ? wr_left : side_bit_reg;
        end
        always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
                word_reg     <= '0;
                side_bit_reg <= 1'b0;
            end else begin
                word_reg     <= word_next;
                side_bit_reg <= side_bit_next;
            end
        end
        assign ent_data[e] = word_reg;
        assign ent_side[e] = side_bit_reg;
    end
endmodule : sdi_sink

// ---- hw/sdi_source.sv ----
// Serial audio source end: drives bit clock, channel select and serial data.
// Assumes the user side offers a stereo pair with valid/ready, held until taken.
`timescale 1ns/1ps
`include "sdi_regs.svh"
module sdi_source (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                nrst,
    // Configuration
    input  wire sdi_pkg::sdi_fmt_t   fmt,
    input  wire sdi_pkg::sdi_wid_t   wid_sel,
    // Stereo pair in
    input  wire logic                pair_valid,
    output logic                     pair_ready,
    input  wire sdi_pkg::sdi_sample_t left_data,
    input  wire sdi_pkg::sdi_sample_t right_data,
    // Link
    sdi_link_if.source               link
);
    logic [7:0] div_reg, div_next;
    logic       bclk_reg, bclk_next;
    logic       lr_reg, lr_next;
    logic       sd_reg, sd_next;
    logic [6:0] pos_reg, pos_next, pos_inc;
    sdi_pkg::sdi_sample_t l_reg, l_next, r_reg, r_next;
    sdi_pkg::sdi_fmt_t fmt_reg, fmt_next, fmt_use;
    sdi_pkg::sdi_wid_t wid_reg, wid_next, wid_use;
    logic [5:0] width, first_slot, slot, bitn;
    logic       tick, second_half;
    sdi_pkg::sdi_sample_t word;

    always_comb begin
        unique case (wid_use)
            `SDI_WID_16: width = 6'd16;
            `SDI_WID_18: width = 6'd18;
            `SDI_WID_20: width = 6'd20;
            default:     width = 6'd24;
        endcase
        unique case (fmt_use)
            `SDI_FMT_I2S: first_slot = 6'd1;
            `SDI_FMT_RJ:  first_slot = `SDI_SLOTS_PER_CH - width;
            default:      first_slot = 6'd0;
        endcase
    end

    // Format and width are taken at the frame wrap, so a change never cuts a half short.
    assign fmt_use     = pair_ready ? fmt : fmt_reg;
    assign wid_use     = pair_ready ? wid_sel : wid_reg;
    assign tick        = div_reg == 8'(`SDI_BCLK_HALF - 1);
    assign pos_inc     = (pos_reg == 7'h3f) ? 7'h00 : pos_reg + 7'h01;
    assign second_half = pos_inc[5];
    assign slot        = {1'b0, pos_inc[4:0]};
    assign bitn        = 6'd23 - (slot - first_slot);
    // A new pair is taken only at a frame boundary on the falling edge.
    assign pair_ready  = tick & bclk_reg & (pos_reg == 7'h3f);

    always_comb begin
        div_next  = tick ? 8'h0 : div_reg + 8'h1;
        bclk_next = bclk_reg;
        lr_next   = lr_reg;
        sd_next   = sd_reg;
        pos_next  = pos_reg;
        l_next    = l_reg;
        r_next    = r_reg;
        fmt_next  = fmt_use;
        wid_next  = wid_use;
        word      = second_half ? r_reg : l_reg;
        if (tick) begin
            bclk_next = ~bclk_reg;
            // Lines change on the falling edge so the sink sees them steady at the rise.
            if (bclk_reg) begin
                pos_next = pos_inc;
                if (pair_ready && pair_valid) begin
                    l_next = left_data;
                    r_next = right_data;
                end
                word    = second_half ? r_next : l_next;
                lr_next = (fmt_use == `SDI_FMT_I2S) ? second_half : ~second_half;
                if (slot >= first_slot && slot < first_slot + width) begin
                    sd_next = word[bitn[4:0]];
                end else begin
                    sd_next = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_reg  <= 8'h0;
            bclk_reg <= 1'b0;
            lr_reg   <= 1'b0;
            sd_reg   <= 1'b0;
            pos_reg  <= 7'h3f;
            l_reg    <= '0;
            r_reg    <= '0;
            fmt_reg  <= `SDI_FMT_RESET;
            wid_reg  <= `SDI_WID_24;
        end else begin
            div_reg  <= div_next;
            bclk_reg <= bclk_next;
            lr_reg   <= lr_next;
            sd_reg   <= sd_next;
            pos_reg  <= pos_next;
            l_reg    <= l_next;
            r_reg    <= r_next;
            fmt_reg  <= fmt_next;
            wid_reg  <= wid_next;
        end
    end

    assign link.bit_clk          = bclk_reg;
    assign link.chan_sel         = lr_reg;
    assign link.serial_sample_in = sd_reg;
endmodule : sdi_source

// ---- bench/sdi_link_asserts.sv ----
// Wire checks of the serial audio link, all sampled on core_clk.
// Assumes the source end drives the link and reset is nrst, low.
`timescale 1ns/1ps
module sdi_link_asserts (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Link
    input wire logic bit_clk,
    input wire logic chan_sel,
    input wire logic serial_sample_in
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic       sel_reg;
    logic       seen_reg;
    logic       seen_next;
    // The first half after reset may be short, so it is never measured.
    always_comb begin
        seen_next = seen_reg | (chan_sel != sel_reg);
        cnt_next  = (chan_sel != sel_reg) ? 8'h00 : cnt_reg + 8'h01;
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg  <= 8'h00;
            sel_reg  <= 1'b0;
            seen_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            sel_reg  <= chan_sel;
            seen_reg <= seen_next;
        end
    end
    a_clk_high_len: assert property ($rose(bit_clk) |-> bit_clk[*4] ##1 !bit_clk)
        else $error("bit clock high phase is not four cycles");
    a_clk_low_len: assert property ($fell(bit_clk) |-> (!bit_clk)[*4] ##1 bit_clk)
        else $error("bit clock low phase is not four cycles");
    a_clk_runs: assert property (1'b1 |-> ##[1:5] $changed(bit_clk))
        else $error("bit clock stopped");
    a_data_on_fall: assert property ($changed(serial_sample_in) |-> $fell(bit_clk))
        else $error("serial data moved away from a falling bit clock");
    a_sel_on_fall: assert property ($changed(chan_sel) |-> $fell(bit_clk))
        else $error("channel select moved away from a falling bit clock");
    a_sel_half_len: assert property (seen_reg && (chan_sel != sel_reg) |-> cnt_reg == 8'hff)
        else $error("channel half is not 32 bit periods");
    a_hold_high: assert property ($rose(bit_clk) |=>
        $stable({chan_sel, serial_sample_in})[*3])
        else $error("link lines moved while bit clock high");
    a_hold_low: assert property ($fell(bit_clk) |=> $stable(serial_sample_in)[*3])
        else $error("serial data moved while bit clock low");
endmodule : sdi_link_asserts

// ---- bench/sdi_link_test.sv ----
// Source and sink joined by the link; checked end to end and on the wire.
// Assumes core_clk at 40 MHz; the source end makes the bit clock.
`timescale 1ns/1ps
`include "sdi_regs.svh"
module sdi_link_test;
    logic                 core_clk = 1'b0;
    logic                 nrst = 1'b0;
    sdi_pkg::sdi_fmt_t    src_fmt = `SDI_FMT_I2S;
    sdi_pkg::sdi_fmt_t    snk_fmt = `SDI_FMT_LJ;
    logic                 ovr = 1'b0;
    sdi_pkg::sdi_wid_t    wid = `SDI_WID_24;
    logic                 pair_ready;
    sdi_pkg::sdi_sample_t left_d = 24'h000000;
    sdi_pkg::sdi_sample_t right_d = 24'h000000;
    logic                 smp_valid;
    logic                 smp_ready = 1'b1;
    sdi_pkg::sdi_sample_t smp_data;
    logic                 smp_left;
    sdi_pkg::sdi_sample_t exp_l, exp_r, wword, wexp, sexp;
    logic                 chk_on = 1'b0, pbclk = 1'b0, psel = 1'b0;
    int                   w = 24, msb = 1, slot = 0, pops = 0, p0;
    int                   fail_count = 0, checked = 0, cycles = 0;
    always #12.5 core_clk = ~core_clk;
    sdi_link_if sdi_link_if_i ();
    sdi_source sdi_source_i (.core_clk(core_clk), .nrst(nrst), .fmt(src_fmt), .wid_sel(wid),
        .pair_valid(1'b1), .pair_ready(pair_ready), .left_data(left_d),
        .right_data(right_d), .link(sdi_link_if_i));
    sdi_sink sdi_sink_i (.core_clk(core_clk), .nrst(nrst), .fmt_sel(snk_fmt),
        .fmt_override(ovr), .wid_sel(wid), .link(sdi_link_if_i), .smp_valid(smp_valid),
        .smp_ready(smp_ready), .smp_data(smp_data), .smp_left(smp_left));
    sdi_link_asserts sdi_link_asserts_i (.core_clk(core_clk), .nrst(nrst),
        .bit_clk(sdi_link_if_i.bit_clk), .chan_sel(sdi_link_if_i.chan_sel),
        .serial_sample_in(sdi_link_if_i.serial_sample_in));
    task automatic tally_and_finish();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task automatic check_word(input string n, input sdi_pkg::sdi_sample_t e, g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : check_word
    task automatic check_int(input string n, input int e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %0d seen %0d", n, e, g);
        end
    endtask : check_int
    // Case 0 leaves the sink without override while the source speaks I2S.
    task automatic run_cfg(input int i);
        sdi_pkg::sdi_sample_t m;
        @(posedge core_clk);
        chk_on <= 1'b0;
        src_fmt <= (i == 0) ? `SDI_FMT_I2S : sdi_pkg::sdi_fmt_t'((i - 1) / 4);
        snk_fmt <= (i == 0) ? `SDI_FMT_LJ : sdi_pkg::sdi_fmt_t'((i - 1) / 4);
        ovr <= (i != 0);
        wid <= (i == 0) ? `SDI_WID_24 : sdi_pkg::sdi_wid_t'((i - 1) % 4);
        w = (i == 0) ? 24 : ((i - 1) % 4 == 3) ? 24 : 16 + 2 * ((i - 1) % 4);
        msb = (i == 0 || (i - 1) / 4 == 1) ? 1 : ((i - 1) / 4 == 0) ? 0 : 32 - w;
        m = ~(24'hffffff >> w);
        left_d <= 24'hc35a96 ^ {i[3:0], 20'h00000};
        right_d <= ~(24'hc35a96 ^ {i[3:0], 20'h00000});
        exp_l = (24'hc35a96 ^ {i[3:0], 20'h00000}) & m;
        exp_r = ~(24'hc35a96 ^ {i[3:0], 20'h00000}) & m;
        repeat (1024) @(posedge core_clk);
        chk_on <= 1'b1;
        p0 = pops;
        repeat (1024) @(posedge core_clk);
        check_int("words per two frames", 4, pops - p0);
    endtask : run_cfg
    always @(posedge core_clk) begin
        pbclk <= sdi_link_if_i.bit_clk;
        if (sdi_link_if_i.bit_clk === 1'b1 && pbclk === 1'b0) begin
            slot = (sdi_link_if_i.chan_sel !== psel) ? 0 : slot + 1;
            psel = sdi_link_if_i.chan_sel;
            if (slot == 0) wword = 24'h000000;
            if (slot >= msb && slot < msb + w) begin
                wword[23 - (slot - msb)] = sdi_link_if_i.serial_sample_in;
            end
            if (chk_on && slot == msb + w - 1) begin
                wexp = (psel === (src_fmt != `SDI_FMT_I2S)) ? exp_l : exp_r;
                check_word("wire word", wexp, wword);
            end
        end
        if (smp_valid === 1'b1 && smp_ready === 1'b1) begin
            pops <= pops + 1;
            if (chk_on) begin
                sexp = (smp_left === 1'b1) ? exp_l : exp_r;
                check_word("smp_data", sexp, smp_data);
            end
        end
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 13; i++) run_cfg(i);
        // The link cannot be stalled, so a stalled reader keeps only two words.
        smp_ready <= 1'b0;
        repeat (900) @(posedge core_clk);
        check_int("valid while stalled", 1, smp_valid);
        p0 = pops;
        smp_ready <= 1'b1;
        repeat (4) @(posedge core_clk);
        check_int("valid after drain", 0, smp_valid);
        check_int("words buffered", 2, pops - p0);
        tally_and_finish();
    end
endmodule : sdi_link_test
